// ==== design/tawg_top.sv ====
// Timed access write guard for protected special function registers
`timescale 1ns/100ps
`default_nettype none

module tawg_top
#(
   parameter logic [7:0] WDOG_ADDR  = 8'hAA,
   parameter logic [7:0] WDOG_RESET = 8'h00,
   parameter logic [7:0] BOD_ADDR   = 8'hAB,
   parameter logic [7:0] BOD_RESET  = 8'h00
)
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire logic                      ce,
   input  wire logic                      wr_en,
   input  wire logic [tawg_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [tawg_pkg::DATA_W-1:0] wr_data,
   input  wire logic [tawg_pkg::ADDR_W-1:0] rd_addr,
   output logic [tawg_pkg::DATA_W-1:0]    rd_data,
   output logic                           window_open,
   output logic [7:0]                     watchdog_control,
   output logic [7:0]                     brownout_control
);

   // ************************************************************
   // Key sequence state
   // ************************************************************
   tawg_pkg::tawg_state_e             state_q;
   tawg_pkg::tawg_state_e             state_d;
   logic [tawg_pkg::CNT_W-1:0]        cnt_q;
   logic [tawg_pkg::CNT_W-1:0]        cnt_d;
   logic [tawg_pkg::DATA_W-1:0]       rd_q;
   logic [tawg_pkg::DATA_W-1:0]       rd_d;
   tawg_pkg::tawg_wr_s                wr;
   logic                              key_wr;
   logic [7:0]                        wdog_val;
   logic [7:0]                        bod_val;
   logic                              window_q;
   logic                              window_d;
   localparam int                     PROT_N     = 2;
   localparam int                     WDOG_IDX   = 0;
   localparam int                     BOD_IDX    = 1;
   localparam logic [PROT_N-1:0][7:0] PROT_ADDR  = {BOD_ADDR, WDOG_ADDR};
   localparam logic [PROT_N-1:0][7:0] PROT_RESET = {BOD_RESET, WDOG_RESET};
   logic [PROT_N-1:0][7:0]            prot_val;

   // Address match, shared by the key decode and the read port
   function automatic logic addr_hit
   (
      input logic [tawg_pkg::ADDR_W-1:0] addr,
      input logic [tawg_pkg::ADDR_W-1:0] match
   );
      addr_hit = (addr == match);
   endfunction

   assign wr     = '{en: wr_en, addr: wr_addr, data: wr_data};
   assign key_wr = wr_en && addr_hit(wr_addr, tawg_pkg::KEY_ADDR);

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         tawg_pkg::TAWG_IDLE:
         begin
            // Only AAH arms; any other key value keeps us idle
            if (key_wr && wr_data == tawg_pkg::KEY_ARM)
            begin
               state_d = tawg_pkg::TAWG_ARMED;
               cnt_d   = tawg_pkg::CNT_W'(tawg_pkg::ARM_CYCLES);
            end
         end
         tawg_pkg::TAWG_ARMED:
         begin
            if (key_wr && wr_data == tawg_pkg::KEY_OPEN)
            begin
               state_d = tawg_pkg::TAWG_OPEN;
               cnt_d   = tawg_pkg::CNT_W'(tawg_pkg::WIN_CYCLES);
            end
            else if (key_wr)
            begin
               state_d = tawg_pkg::TAWG_IDLE;
               cnt_d   = tawg_pkg::CNT_ZERO;
            end
            else if (cnt_q == tawg_pkg::CNT_ONE)
            begin
               state_d = tawg_pkg::TAWG_IDLE;
               cnt_d   = tawg_pkg::CNT_ZERO;
            end
            else
            begin
               cnt_d = cnt_q - tawg_pkg::CNT_ONE;
            end
         end
         tawg_pkg::TAWG_OPEN:
         begin
            // Closes on its own; a fresh key pair is needed after
            if (cnt_q == tawg_pkg::CNT_ONE)
            begin
               state_d = tawg_pkg::TAWG_IDLE;
               cnt_d   = tawg_pkg::CNT_ZERO;
            end
            else
            begin
               cnt_d = cnt_q - tawg_pkg::CNT_ONE;
            end
         end
         default:
         begin
            state_d = tawg_pkg::TAWG_IDLE;
            cnt_d   = tawg_pkg::CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= tawg_pkg::TAWG_IDLE;
         cnt_q   <= tawg_pkg::CNT_ZERO;
      end
      else if (ce)
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // ************************************************************
   // Window flag
   // ************************************************************
   // Registered from the next state so the pin comes from a flop
   always_comb
   begin
      window_d = 1'b0;
      if (state_d == tawg_pkg::TAWG_OPEN)
      begin
         window_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         window_q <= 1'b0;
      end
      else if (ce)
      begin
         window_q <= window_d;
      end
   end

   assign window_open = window_q;

   // ************************************************************
   // Protected registers
   // ************************************************************
   genvar g;

   generate
      for (g = 0; g < PROT_N; g = g + 1)
      begin : g_prot
         tawg_prot_reg #(.ADDR(PROT_ADDR[g]), .RESET(PROT_RESET[g])) u_reg
         (
            .clk         (clk),
            .rst         (rst),
            .ce          (ce),
            .wr          (wr),
            .window_open (window_q),
            .value       (prot_val[g])
         );
      end
   endgenerate

   assign wdog_val         = prot_val[WDOG_IDX];
   assign bod_val          = prot_val[BOD_IDX];
   assign watchdog_control = wdog_val;
   assign brownout_control = bod_val;

   // ************************************************************
   // Read port, registered; key reads as zero since it is write-only
   // ************************************************************
   always_comb
   begin
      rd_d = tawg_pkg::KEY_RESET;
      if (addr_hit(rd_addr, WDOG_ADDR))
      begin
         rd_d = wdog_val;
      end
      else if (addr_hit(rd_addr, BOD_ADDR))
      begin
         rd_d = bod_val;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rd_q <= tawg_pkg::KEY_RESET;
      end
      else if (ce)
      begin
         rd_q <= rd_d;
      end
   end

   assign rd_data = rd_q;

endmodule

`default_nettype wire

// ==== design/tawg_pkg.sv ====
// Package of constants and carriers for the timed access write guard
package tawg_pkg;

   // ************************************************************
   // Register bus
   // ************************************************************
   localparam int            ADDR_W         = 8;
   localparam int            DATA_W         = 8;
   localparam logic [7:0]    KEY_ADDR       = 8'hC7;
   localparam logic [7:0]    KEY_RESET      = 8'h00;
   localparam logic [7:0]    KEY_ARM        = 8'hAA;
   localparam logic [7:0]    KEY_OPEN       = 8'h55;

   // ************************************************************
   // Timing, in clock cycles
   // ************************************************************
   localparam int            ARM_CYCLES     = 3;
   localparam int            WIN_CYCLES     = 4;
   localparam int            CNT_W          = 3;
   localparam logic [2:0]    CNT_ZERO       = 3'h0;
   localparam logic [2:0]    CNT_ONE        = 3'h1;

   // ************************************************************
   // Guard states and write carrier
   // ************************************************************
   typedef enum logic [1:0]
   {
      TAWG_IDLE  = 2'b00,
      TAWG_ARMED = 2'b01,
      TAWG_OPEN  = 2'b10
   } tawg_state_e;

   typedef struct packed
   {
      logic              en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } tawg_wr_s;

endpackage

// ==== design/tawg_prot_reg.sv ====
// One protected register: writes land only while the window is open
`timescale 1ns/100ps
`default_nettype none

module tawg_prot_reg
#(
   parameter logic [7:0] ADDR  = 8'hAA,
   parameter logic [7:0] RESET = 8'h00
)
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   input  wire tawg_pkg::tawg_wr_s wr,
   input  wire logic              window_open,
   output logic [7:0]             value
);

   logic [7:0] value_q;
   logic [7:0] value_d;

   // ************************************************************
   // Next value
   // ************************************************************
   always_comb
   begin
      value_d = value_q;
      // Writes outside the window are dropped silently
      if (wr.en && wr.addr == ADDR && window_open)
      begin
         value_d = wr.data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         value_q <= RESET;
      end
      else if (ce)
      begin
         value_q <= value_d;
      end
   end

   assign value = value_q;

endmodule

`default_nettype wire

// ==== test/tawg_props.sv ====
// Checker of the write guard's port behaviour
`timescale 1ns/100ps
`default_nettype none
module tawg_props
#(
   parameter logic [7:0] WDOG_ADDR  = 8'hAA,
   parameter logic [7:0] WDOG_RESET = 8'h00,
   parameter logic [7:0] BOD_ADDR   = 8'hAB,
   parameter logic [7:0] BOD_RESET  = 8'h00
)
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       ce,
   input wire logic       wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic       window_open,
   input wire logic [7:0] watchdog_control,
   input wire logic [7:0] brownout_control
);
   // ************************************************
   // Key decode and properties
   // ************************************************
   wire logic kw = wr_en && wr_addr == tawg_pkg::KEY_ADDR;
   wire logic ka = kw && wr_data == tawg_pkg::KEY_ARM;
   wire logic k5 = kw && wr_data == tawg_pkg::KEY_OPEN;
   // Frozen cycles are skipped, since ce low holds all state
   default clocking @(posedge clk); endclocking
   default disable iff (rst || !ce);
   a_open_len: assert property ($rose(window_open) |->
      window_open [*4] ##1 !window_open) else $error("window length");
   a_open_cause: assert property ($rose(window_open) |-> $past(k5))
      else $error("window opened without key");
   a_arm_open: assert property (!kw [*3] ##1 ka && !window_open
      ##1 k5 |=> window_open) else $error("key pair ignored");
   a_late_shut: assert property (ka && !window_open ##1 !kw [*3]
      ##1 k5 |=> !window_open) else $error("late key opened");
   a_wrong_key: assert property (ka && !window_open ##1 kw && !ka
      && !k5 ##1 k5 |=> !window_open) else $error("bad key kept arm");
   a_wdog_hold: assert property (!window_open |=>
      $stable(watchdog_control)) else $error("watchdog changed");
   a_wdog_wr: assert property (window_open && wr_en &&
      wr_addr == WDOG_ADDR |=> watchdog_control == $past(wr_data))
      else $error("watchdog write lost");
   a_bod_wr: assert property (window_open && wr_en &&
      wr_addr == BOD_ADDR |=> brownout_control == $past(wr_data))
      else $error("brownout write lost");
   a_read_back: assert property (rd_addr == BOD_ADDR |=>
      rd_data == $past(brownout_control)) else $error("read wrong");
   a_key_hidden: assert property (rd_addr == tawg_pkg::KEY_ADDR |=>
      rd_data == 8'h00) else $error("key readable");
   a_bod_hold: assert property (!window_open |=>
      $stable(brownout_control)) else $error("brownout changed");
   a_wdog_read: assert property (rd_addr == WDOG_ADDR |=>
      rd_data == $past(watchdog_control)) else $error("read wrong");
   a_reset_idle: assert property (disable iff (1'b0) rst |=>
      !window_open && watchdog_control == WDOG_RESET &&
      brownout_control == BOD_RESET && rd_data == 8'h00)
      else $error("reset state");
endmodule
bind tawg_top tawg_props #(.WDOG_ADDR(WDOG_ADDR), .WDOG_RESET(WDOG_RESET),
   .BOD_ADDR(BOD_ADDR), .BOD_RESET(BOD_RESET)) i_props (.clk, .rst, .ce,
   .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_data, .window_open,
   .watchdog_control, .brownout_control);
`default_nettype wire

// ==== test/tawg_cpu.sv ====
// Model of the processor core on the register write and read buses
`timescale 1ns/100ps
`default_nettype none
module tawg_cpu
(
   input  wire logic       clk,
   output logic            wr_en,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data
);
   // ************************************************
   // Bus tasks
   // ************************************************
   initial
   begin
      wr_en   = 1'b0;
      wr_addr = 8'h00;
      wr_data = 8'h00;
      rd_addr = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
   endtask
   // Idle data toggles so a stale byte never looks valid
   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clk);
         wr_en   <= 1'b0;
         wr_data <= ~wr_data;
      end
   endtask
   // Whole pair every time, with gap idle cycles between the two key writes
   task automatic unlock(input int gap, input logic [7:0] k2);
      wr(tawg_pkg::KEY_ADDR, tawg_pkg::KEY_ARM);
      idle(gap);
      wr(tawg_pkg::KEY_ADDR, k2);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      wr_en   <= 1'b0;
      rd_addr <= a;
      @(posedge clk);
      #1 v = rd_data;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench of the timed access write guard
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   localparam logic [7:0] WD = 8'hAA;
   localparam logic [7:0] BD = 8'hAB;
   logic       clk;
   logic       rst;
   logic       we;
   logic [7:0] wa;
   logic [7:0] wd;
   logic [7:0] ra;
   logic [7:0] rdat;
   logic       win;
   logic       ce;
   logic [7:0] wdc;
   logic [7:0] bdc;
   logic [7:0] v;
   int         bad_count = 0;
   int         check_count = 0;
   int         cycles = 0;
   // ************************************************
   // Harness and shared tasks
   // ************************************************
   tawg_cpu i_cpu (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd),
      .rd_addr(ra), .rd_data(rdat));
   tawg_top #(.WDOG_ADDR(WD), .BOD_ADDR(BD)) i_dut (.clk(clk), .rst(rst),
      .ce(ce), .wr_en(we), .wr_addr(wa), .wr_data(wd), .rd_addr(ra),
      .rd_data(rdat), .window_open(win), .watchdog_control(wdc),
      .brownout_control(bdc));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      i_cpu.rd(a, v);
      check(v, exp);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Whole run is under a hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         bad_count++;
         end_sim();
      end
   end
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rc(WD, 8'h00);
      rc(8'hC7, 8'h00);
      i_cpu.wr(WD, 8'h11);
      rc(WD, 8'h00);
      $display("reset and locked write done");
      i_cpu.unlock(0, 8'h55);
      i_cpu.wr(WD, 8'h5A);
      i_cpu.idle(2);
      i_cpu.wr(BD, 8'hA5);
      i_cpu.wr(BD, 8'hFF);
      rc(WD, 8'h5A);
      check(wdc, 8'h5A);
      rc(BD, 8'hA5);
      $display("window edges done");
      i_cpu.unlock(2, 8'h55);
      i_cpu.wr(BD, 8'h3C);
      rc(BD, 8'h3C);
      check(bdc, 8'h3C);
      i_cpu.unlock(3, 8'h55);
      i_cpu.wr(BD, 8'h77);
      rc(BD, 8'h3C);
      i_cpu.unlock(0, 8'h12);
      i_cpu.wr(8'hC7, 8'h55);
      i_cpu.wr(BD, 8'h77);
      rc(BD, 8'h3C);
      $display("key timing done");
      // Frozen cycles must not count against the arming time
      i_cpu.wr(8'hC7, 8'hAA);
      i_cpu.idle(1);
      ce <= 1'b0;
      repeat (6) @(posedge clk);
      ce <= 1'b1;
      i_cpu.wr(8'hC7, 8'h55);
      i_cpu.wr(BD, 8'h4B);
      rc(BD, 8'h4B);
      check(bdc, 8'h4B);
      $display("clock enable freeze done");
      // Reset lands while the window is open
      i_cpu.unlock(0, 8'h55);
      i_cpu.idle(1);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      i_cpu.wr(BD, 8'h99);
      rc(BD, 8'h00);
      check({7'h00, win}, 8'h00);
      $display("mid-run reset done");
      end_sim();
   end
endmodule
`default_nettype wire
